// ---- hdl/amse_defines.svh ----
// constants for the adapter module status and enable block
// What this block does
// RULE1: all module status terminals are registered on the one status clock.
// RULE2: eeprom power flag is high exactly while the eeprom rail is switched on.
// RULE3: expected module id is a 32-bit build-time constant exposed to users.
// RULE4: inserted module id is the 32-bit id read from the attached module.
// RULE5: module is compatible only on an all-bit id match; otherwise it stays off.
// RULE6: user io pins enable only with module attached, powered, and compatible.
// RULE7: io enabled flag mirrors the io pin enable.
// RULE8: main power switches on only for an attached, compatible module.
// RULE9: power enabled flag is high only while main power is fully on.
// RULE10: power good input is mirrored as a flag; module asserts it once rails settle.
// RULE11: module present flag follows physical attachment.
// RULE12: temperature from the external sensor is returned as whole degrees per count.
// RULE13: temperature output is registered on the status clock.
// RULE14: user logic waits 250 ms after reset before trusting temperature.
// RULE15: four debug leds are bits 3:0 of a 32-bit read/write value.
// RULE16: sequence presence, id check, power, power good, io; removal drops all at once.
`ifndef AMSE_DEFINES_SVH
`define AMSE_DEFINES_SVH

// ==========================================================
// register byte addresses
`define AMSE_ADDR_CTRL     8'h00
`define AMSE_ADDR_STATUS   8'h04
`define AMSE_ADDR_EXP_ID   8'h08
`define AMSE_ADDR_INS_ID   8'h0C
`define AMSE_ADDR_TEMP     8'h10
`define AMSE_ADDR_LED      8'h14
`define AMSE_ADDR_IRQ_STAT 8'h18
`define AMSE_ADDR_IRQ_MASK 8'h1C
`define AMSE_ADDR_TEMP_RDY 8'h20

// ==========================================================
// field positions
`define AMSE_CTRL_EEPROM_BIT 0
`define AMSE_ST_PRESENT_BIT  0
`define AMSE_ST_COMPAT_BIT   1
`define AMSE_ST_PWR_EN_BIT   2
`define AMSE_ST_PWR_GOOD_BIT 3
`define AMSE_ST_IO_EN_BIT    4
`define AMSE_ST_EEPROM_BIT   5
`define AMSE_IRQ_WIDTH       5

// ==========================================================
// reset values and timing
`define AMSE_CTRL_RST      1'h1
`define AMSE_LED_RST       4'h0
`define AMSE_IRQ_MASK_RST  5'h00
`define AMSE_TEMP_WAIT_MS  250
`define AMSE_CLK_MHZ       100
`define AMSE_TEMP_WAIT_CYC (`AMSE_TEMP_WAIT_MS * 1000 * `AMSE_CLK_MHZ)

`endif

// ---- hdl/amse_pkg.sv ----
// types for the adapter module status and enable block
package amse_pkg;
  typedef enum logic [2:0] {
    AMSE_IDLE,
    AMSE_CHECK,
    AMSE_POWER,
    AMSE_WAIT_PG,
    AMSE_RUN,
    AMSE_REJECT
  } amse_state_t;
endpackage

// ---- hdl/amse_seq_if.sv ----
// interface between the bus slave and the enable sequencer
`timescale 1ns/10ps
`default_nettype none
interface amse_seq_if;
  logic        present;
  logic        pwr_good;
  logic [31:0] exp_id;
  logic [31:0] ins_id;
  logic        compat;
  logic        pwr_en;
  logic        io_en;
  logic        removed;
  modport seq (input present, pwr_good, exp_id, ins_id,
               output compat, pwr_en, io_en, removed);
  modport top (output present, pwr_good, exp_id, ins_id,
               input compat, pwr_en, io_en, removed);
endinterface
`default_nettype wire

// ---- hdl/amse_seq.sv ----
// enable sequencer: presence, id match, power, power good, io enable
`timescale 1ns/10ps
`default_nettype none
`include "amse_defines.svh"
module amse_seq
(
  input  wire logic   ref_clk_i,
  input  wire logic   rst_b_i,
  amse_seq_if.seq     sq
);
  amse_pkg::amse_state_t state_r;
  amse_pkg::amse_state_t state_nxt;
  logic                  was_present_r;

  // ==========================================================
  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      amse_pkg::AMSE_IDLE:    if (sq.present) state_nxt = amse_pkg::AMSE_CHECK;
      amse_pkg::AMSE_CHECK:                                           // RULE5
        state_nxt = (sq.ins_id == sq.exp_id) ? amse_pkg::AMSE_POWER
                                             : amse_pkg::AMSE_REJECT;
      amse_pkg::AMSE_POWER:   state_nxt = amse_pkg::AMSE_WAIT_PG;     // RULE8
      amse_pkg::AMSE_WAIT_PG: if (sq.pwr_good) state_nxt = amse_pkg::AMSE_RUN; // RULE10
      amse_pkg::AMSE_RUN:     if (!sq.pwr_good) state_nxt = amse_pkg::AMSE_WAIT_PG;
      amse_pkg::AMSE_REJECT:  state_nxt = amse_pkg::AMSE_REJECT;
      default:                state_nxt = amse_pkg::AMSE_IDLE;
    endcase
    // removal overrides everything, power and io drop together
    if (!sq.present) state_nxt = amse_pkg::AMSE_IDLE;                 // RULE16
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i) state_r <= amse_pkg::AMSE_IDLE;
    else          state_r <= state_nxt;
  end

  // ==========================================================
  // presence history for the removal event
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i) was_present_r <= 1'b0;
    else          was_present_r <= sq.present;
  end

  // ==========================================================
  // outputs decoded from state, removal from presence history; power needs no good signal, io does
  assign sq.compat  = (state_r == amse_pkg::AMSE_POWER) || (state_r == amse_pkg::AMSE_WAIT_PG)
                      || (state_r == amse_pkg::AMSE_RUN);             // RULE5
  assign sq.pwr_en  = sq.compat && (state_r != amse_pkg::AMSE_POWER) && sq.present; // RULE8
  assign sq.io_en   = (state_r == amse_pkg::AMSE_RUN) && sq.present
                      && sq.pwr_good;                                 // RULE6
  assign sq.removed = was_present_r && !sq.present;
endmodule // amse_seq
`default_nettype wire

// ---- hdl/amse_top.sv ----
// adapter module status and enable block with axi4-lite register access
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "amse_defines.svh"
module amse_top
#(
  parameter logic [31:0] EXPECTED_ID   = 32'h0000_1234, // arbitrary value
  parameter int          TEMP_WAIT_CYC = `AMSE_TEMP_WAIT_CYC
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // adapter module connector
  input  wire logic        mod_present_i,
  input  wire logic        mod_pwr_good_i,
  input  wire logic [31:0] mod_id_i,
  output logic             mod_pwr_en_o,
  output logic             mod_io_en_o,
  output logic             mod_eeprom_pwr_o,
  // external temperature sensor
  input  wire logic [7:0]  sensor_temp_i,
  // user-side status terminals
  output logic             present_o,
  output logic             pwr_good_o,
  output logic             pwr_enabled_o,
  output logic             io_enabled_o,
  output logic             eeprom_pwr_enabled_o,
  output logic [31:0]      expected_id_o,
  output logic [31:0]      inserted_id_o,
  output logic [7:0]       temp_o,
  output logic [3:0]       led_o,
  output logic             irq_o
);
  // a zero wait would hold the ready flag low until the 32-bit counter reaches all ones
  if (TEMP_WAIT_CYC < 1)
  begin : g_bad_wait
    $error("TEMP_WAIT_CYC must be at least 1");
  end

  // carrier for the sequencer, then bus and register state
  amse_seq_if sq ();
  logic                         eeprom_en_r;
  logic [3:0]                   led_r;
  logic [7:0]                   temp_r;
  logic                         temp_rdy_r;
  logic [31:0]                  wait_cnt_r;
  logic [`AMSE_IRQ_WIDTH-1:0]   irq_stat_r;
  logic [`AMSE_IRQ_WIDTH-1:0]   irq_mask_r;
  logic [`AMSE_IRQ_WIDTH-1:0]   ev;
  logic [5:0]                   status;
  logic                         pg_q_r;
  logic                         ioen_q_r;
  logic                         aw_ok_r;
  logic                         w_ok_r;
  logic [7:0]                   awaddr_r;
  logic [31:0]                  wdata_r;
  logic [3:0]                   wstrb_r;
  logic                         do_wr;
  logic                         do_rd;
  logic                         stat_rd;
  logic                         ev_insert;
  logic                         ev_temp_rdy;
  logic                         ev_io_rise;
  logic                         ev_removed;
  logic                         ev_pg_fall;

  // ==========================================================
  // sequencer
  assign sq.present  = mod_present_i;
  assign sq.pwr_good = mod_pwr_good_i;
  assign sq.exp_id   = EXPECTED_ID;
  assign sq.ins_id   = mod_id_i;

  amse_seq u_seq
  (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .sq        (sq)
  );

  // pins act at once; a registered copy would leave power on after removal
  assign mod_pwr_en_o     = sq.pwr_en;                         // RULE8
  assign mod_io_en_o      = sq.io_en;                          // RULE6
  assign mod_eeprom_pwr_o = eeprom_en_r;

  // ==========================================================
  // status terminals, all registered on the one clock
  // the copies lag their sources by one clock; the pins above do not
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      present_o            <= 1'b0;
      pwr_good_o           <= 1'b0;
      pwr_enabled_o        <= 1'b0;
      io_enabled_o         <= 1'b0;
      eeprom_pwr_enabled_o <= 1'b0;
      expected_id_o        <= 32'h0000_0000;
      inserted_id_o        <= 32'h0000_0000;
    end
    else
    begin
      present_o            <= mod_present_i;                   // RULE11 RULE1
      pwr_good_o           <= mod_pwr_good_i;                  // RULE10
      pwr_enabled_o        <= sq.pwr_en;                       // RULE9
      io_enabled_o         <= sq.io_en;                        // RULE7
      eeprom_pwr_enabled_o <= eeprom_en_r;                     // RULE2
      expected_id_o        <= EXPECTED_ID;                     // RULE3
      inserted_id_o        <= mod_present_i ? mod_id_i : 32'h0000_0000; // RULE4
    end
  end

  // ==========================================================
  // temperature sample and settle timer
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i) temp_r <= 8'h00;
    else          temp_r <= sensor_temp_i;                     // RULE12 RULE13
  end
  assign temp_o = temp_r;

  // readiness flag only advises; readers still own the wait
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      wait_cnt_r <= 32'h0000_0000;
      temp_rdy_r <= 1'b0;
    end
    else if (!temp_rdy_r)
    begin
      wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
      temp_rdy_r <= (wait_cnt_r == 32'(TEMP_WAIT_CYC - 1));    // RULE14
    end
  end

  // ==========================================================
  // events: sticky bits, read of the event register clears them
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      pg_q_r   <= 1'b0;
      ioen_q_r <= 1'b0;
    end
    else
    begin
      pg_q_r   <= mod_pwr_good_i;
      ioen_q_r <= sq.io_en;
    end
  end
  // one-clock pulses; all but the temperature-ready one compare a level with its copy from the clock before
  assign ev_insert   = mod_present_i & ~present_o;
  assign ev_temp_rdy = !temp_rdy_r && (wait_cnt_r == 32'(TEMP_WAIT_CYC - 1));
  assign ev_io_rise  = sq.io_en & ~ioen_q_r;
  assign ev_removed  = sq.removed;
  assign ev_pg_fall  = pg_q_r & ~mod_pwr_good_i;
  assign ev          = {ev_pg_fall, ev_removed, ev_io_rise, ev_temp_rdy, ev_insert};

  // a read of the event register clears it; the read data carry the old bits
  assign stat_rd = do_rd && (s_axi_araddr == `AMSE_ADDR_IRQ_STAT);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i) irq_stat_r <= '0;
    else if (stat_rd)
      irq_stat_r <= ev;                                        // set wins over clear
    else irq_stat_r <= irq_stat_r | ev;
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ==========================================================
  // axi4-lite write path: address and data in either order
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      aw_ok_r  <= 1'b0;
      w_ok_r   <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (do_wr) aw_ok_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r  <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (do_wr) w_ok_r <= 1'b0;
    end
  end
  // ready drops while a half is held or a response waits: one write at a time
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  assign do_wr         = aw_ok_r && w_ok_r;

  // writable registers
  // only byte lane 0 holds a field, so the upper strobes are ignored
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      eeprom_en_r <= `AMSE_CTRL_RST;
      led_r       <= `AMSE_LED_RST;
      irq_mask_r  <= `AMSE_IRQ_MASK_RST;
    end
    else if (do_wr && wstrb_r[0])
    begin
      case (awaddr_r)
        `AMSE_ADDR_CTRL:     eeprom_en_r <= wdata_r[`AMSE_CTRL_EEPROM_BIT];
        `AMSE_ADDR_LED:      led_r       <= wdata_r[3:0];          // RULE15
        `AMSE_ADDR_IRQ_MASK: irq_mask_r  <= wdata_r[`AMSE_IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end
  assign led_o = led_r;

  // write response; unmapped address answers slverr
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == `AMSE_ADDR_CTRL || awaddr_r == `AMSE_ADDR_LED
                       || awaddr_r == `AMSE_ADDR_IRQ_MASK) ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // axi4-lite read path, one cycle after address acceptance
  assign s_axi_arready = !s_axi_rvalid;
  assign do_rd         = s_axi_arvalid && s_axi_arready;
  // live levels, so software sees the present state, not the one-clock copies
  assign status        = {eeprom_en_r, sq.io_en, mod_pwr_good_i, sq.pwr_en,
                          sq.compat, mod_present_i};

  // read data register; unmapped offsets answer slverr with zero data
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (do_rd)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `AMSE_ADDR_CTRL:     s_axi_rdata <= {31'h0, eeprom_en_r};
        `AMSE_ADDR_STATUS:   s_axi_rdata <= {26'h0, status};
        `AMSE_ADDR_EXP_ID:   s_axi_rdata <= EXPECTED_ID;
        `AMSE_ADDR_INS_ID:   s_axi_rdata <= inserted_id_o;
        `AMSE_ADDR_TEMP:     s_axi_rdata <= {24'h0, temp_r};
        `AMSE_ADDR_LED:      s_axi_rdata <= {28'h0, led_r};      // RULE15
        `AMSE_ADDR_IRQ_STAT: s_axi_rdata <= {27'h0, irq_stat_r};
        `AMSE_ADDR_IRQ_MASK: s_axi_rdata <= {27'h0, irq_mask_r};
        `AMSE_ADDR_TEMP_RDY: s_axi_rdata <= {31'h0, temp_rdy_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule // amse_top
`default_nettype wire

// ---- test/amse_props.sv ----
// concurrent checks on the ports of the adapter module status and enable block
`timescale 1ns/10ps
`default_nettype none
module amse_props
#(
  parameter logic [31:0] EXPECTED_ID = 32'h0000_0000
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        mod_present_i,
  input  wire logic        mod_pwr_good_i,
  input  wire logic [31:0] mod_id_i,
  input  wire logic [7:0]  sensor_temp_i,
  input  wire logic        mod_pwr_en_o,
  input  wire logic        mod_io_en_o,
  input  wire logic        mod_eeprom_pwr_o,
  input  wire logic        present_o,
  input  wire logic        pwr_good_o,
  input  wire logic        pwr_enabled_o,
  input  wire logic        io_enabled_o,
  input  wire logic        eeprom_pwr_enabled_o,
  input  wire logic [31:0] expected_id_o,
  input  wire logic [31:0] inserted_id_o,
  input  wire logic [7:0]  temp_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // insertion steps: presence rise with a matching or a foreign id
  sequence s_good_in;
    $rose(mod_present_i) && mod_id_i == EXPECTED_ID;
  endsequence
  sequence s_bad_in;
    $rose(mod_present_i) && mod_id_i != EXPECTED_ID;
  endsequence
  // ==========================================================
  // sequencing and gating
  a_power_up_bound: assert property (s_good_in |-> ##[1:6] mod_pwr_en_o)
    else $error("power not enabled after matching insertion");
  a_foreign_stays_off: assert property (s_bad_in |-> !mod_pwr_en_o [*8])
    else $error("power enabled for foreign module");
  a_power_needs_match: assert property (mod_pwr_en_o |-> mod_present_i && mod_id_i == EXPECTED_ID)
    else $error("power on without attached matching module");
  a_io_needs_all: assert property (mod_io_en_o |-> mod_present_i && mod_pwr_good_i && mod_pwr_en_o)
    else $error("io enabled too early");
  a_io_after_good: assert property ($rose(mod_pwr_good_i) && mod_pwr_en_o |-> ##[1:3] mod_io_en_o)
    else $error("io not enabled after power good");
  a_drop_on_removal: assert property (!mod_present_i |-> !mod_pwr_en_o && !mod_io_en_o)
    else $error("enables kept without module");
  // ==========================================================
  // status terminals: registered copies one clock late
  a_flags_lag: assert property ($past(rst_b_i) |-> present_o == $past(mod_present_i) && pwr_good_o == $past(mod_pwr_good_i) && pwr_enabled_o == $past(mod_pwr_en_o) && io_enabled_o == $past(mod_io_en_o))
    else $error("status flag does not follow its source");
  a_eeprom_flag: assert property ($past(rst_b_i) |-> eeprom_pwr_enabled_o == $past(mod_eeprom_pwr_o))
    else $error("eeprom flag does not follow rail");
  a_temp_copy: assert property ($past(rst_b_i) |-> temp_o == $past(sensor_temp_i))
    else $error("temperature not passed through");
  a_id_terms: assert property ($past(rst_b_i) |-> expected_id_o == EXPECTED_ID && inserted_id_o == ($past(mod_present_i) ? $past(mod_id_i) : 32'h0))
    else $error("id terminal wrong");
endmodule // amse_props
`default_nettype wire

// ---- test/amse_mod_model.sv ----
// behavioural model of the plug-in adapter module on the carrier connector
`timescale 1ns/10ps
`default_nettype none
module amse_mod_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        attach_i,
  input  wire logic [31:0] id_i,
  input  wire logic [3:0]  pg_dly_i,
  input  wire logic        pwr_en_i,
  output logic             present_o,
  output logic             pwr_good_o,
  output var logic [31:0]  id_o
);
  logic [3:0] settle_r = 4'h0;
  initial present_o = 1'h0;
  initial id_o = 32'h0;
  // rail settle counter; unplugged id lines float, so they toggle instead of holding
  always @(posedge ref_clk_i)
  begin
    present_o <= attach_i;
    id_o <= attach_i ? id_i : ~id_o;
    if (!attach_i || !pwr_en_i)
      settle_r <= 4'h0;
    else if (settle_r != 4'hF)
      settle_r <= settle_r + 4'h1;
  end
  // power good only once the rails had more than pg_dly_i clocks to settle
  assign pwr_good_o = attach_i && pwr_en_i && (settle_r > pg_dly_i);
endmodule // amse_mod_model
`default_nettype wire

// ---- test/test_adapter_module_status_enable.sv ----
// self-checking bench for the adapter module status and enable block
`timescale 1ns/10ps
`default_nettype none
`include "amse_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_adapter_module_status_enable;
  localparam logic [31:0] EXP_ID = 32'hA5C3_0F1E; // arbitrary value
  logic        ref_clk_i = 1'h0, rst_b_i = 1'h0, attach = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sensor_temp_i = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, mod_id = 32'h0, seed = 32'h18;
  logic [3:0]  s_axi_wstrb = 4'hF, pg_dly = 4'h5;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, mod_id_i, expected_id_o, inserted_id_o;
  logic        mod_present_i, mod_pwr_good_i, mod_pwr_en_o, mod_io_en_o, mod_eeprom_pwr_o;
  logic        present_o, pwr_good_o, pwr_enabled_o, io_enabled_o, eeprom_pwr_enabled_o, irq_o;
  logic [7:0]  temp_o;
  logic [3:0]  led_o;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [33:0] want_r;
  logic [1:0]  want_b;
  int          fails = 0, compares = 0, n;

  amse_top #(.EXPECTED_ID(EXP_ID), .TEMP_WAIT_CYC(20)) uut (.ref_clk_i, .rst_b_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_present_i,
    .mod_pwr_good_i, .mod_id_i, .mod_pwr_en_o, .mod_io_en_o, .mod_eeprom_pwr_o, .sensor_temp_i,
    .present_o, .pwr_good_o, .pwr_enabled_o, .io_enabled_o, .eeprom_pwr_enabled_o,
    .expected_id_o, .inserted_id_o, .temp_o, .led_o, .irq_o);
  amse_mod_model u_mod (.ref_clk_i, .attach_i(attach), .id_i(mod_id), .pg_dly_i(pg_dly),
    .pwr_en_i(mod_pwr_en_o), .present_o(mod_present_i), .pwr_good_o(mod_pwr_good_i),
    .id_o(mod_id_i));

  // ==========================================================
  // clock, random source, closing
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
    end
  endfunction
  task automatic complete_run();
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  // ==========================================================
  // bus master: each channel held until its own ready, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    int   k;
    begin
      pa = 1'h1;
      pw = 1'h1;
      k = 0;
      exp_b.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
        @(posedge ref_clk_i);
        k++;
        if (pa && s_axi_awready)
        begin
          pa = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (pw && s_axi_wready)
        begin
          pw = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
      end while (!(s_axi_bvalid && !pa && !pw) && k < 200);
      if (!(s_axi_bvalid && !pa && !pw)) fails++;
      s_axi_bready <= 1'h0;
      @(posedge ref_clk_i);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic pa;
    int   k;
    begin
      pa = 1'h1;
      k = 0;
      exp_r.push_back({er, ed});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
        @(posedge ref_clk_i);
        k++;
        if (pa && s_axi_arready)
        begin
          pa = 1'h0;
          s_axi_arvalid <= 1'h0;
        end
      end while (!(s_axi_rvalid && !pa) && k < 200);
      if (!(s_axi_rvalid && !pa)) fails++;
      s_axi_rready <= 1'h0;
      @(posedge ref_clk_i);
    end
  endtask

  // response watcher: oldest note is compared when a response is taken
  always @(posedge ref_clk_i)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0)
    begin
      want_r = exp_r.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, want_r)
    end
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
    begin
      want_b = exp_b.pop_front();
      `CHK(s_axi_bresp, want_b)
    end
  end

  // watchdog: the whole sequence needs well under two thousand clocks
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    @(posedge ref_clk_i);
    rd(`AMSE_ADDR_CTRL, 32'h1, 2'h0);
    rd(`AMSE_ADDR_EXP_ID, EXP_ID, 2'h0);
    rd(`AMSE_ADDR_LED, 32'h0, 2'h0);
    rd(`AMSE_ADDR_IRQ_MASK, 32'h0, 2'h0);
    `CHK(irq_o, 1'h0)
    rd(`AMSE_ADDR_STATUS, 32'h20, 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    wr(8'h28, 32'h5, 2'h2);
    done("reset and map");
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wr(`AMSE_ADDR_LED, seed, 2'h0);
      `CHK(led_o, seed[3:0])
      rd(`AMSE_ADDR_LED, {28'h0, seed[3:0]}, 2'h0);
    end
    wr(`AMSE_ADDR_CTRL, 32'h0, 2'h0);
    `CHK(mod_eeprom_pwr_o, 1'h0)
    rd(`AMSE_ADDR_STATUS, 32'h0, 2'h0);
    wr(`AMSE_ADDR_CTRL, 32'h1, 2'h0);
    seed = xs(seed);
    sensor_temp_i <= seed[7:0];
    repeat (2) @(posedge ref_clk_i);
    rd(`AMSE_ADDR_TEMP_RDY, 32'h1, 2'h0);
    rd(`AMSE_ADDR_TEMP, {24'h0, seed[7:0]}, 2'h0);
    done("leds eeprom temperature");
    // foreign module: id bit 0 always differs, other bits at random, so power must stay off
    seed = xs(seed);
    mod_id <= EXP_ID ^ (seed | 32'h1);
    attach <= 1'h1;
    repeat (20) @(posedge ref_clk_i);
    `CHK(mod_pwr_en_o, 1'h0)
    rd(`AMSE_ADDR_STATUS, 32'h21, 2'h0);
    rd(`AMSE_ADDR_INS_ID, EXP_ID ^ (seed | 32'h1), 2'h0);
    attach <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    rd(`AMSE_ADDR_IRQ_STAT, 32'hB, 2'h0);
    done("foreign module");
    // matching module: power, settle, then io; only the io event is unmasked
    wr(`AMSE_ADDR_IRQ_MASK, 32'h4, 2'h0);
    mod_id <= EXP_ID;
    attach <= 1'h1;
    n = 0;
    while (mod_io_en_o !== 1'h1 && n < 60)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK(mod_io_en_o, 1'h1)
    repeat (2) @(posedge ref_clk_i);
    `CHK(irq_o, 1'h1)
    rd(`AMSE_ADDR_STATUS, 32'h3F, 2'h0);
    rd(`AMSE_ADDR_IRQ_STAT, 32'h5, 2'h0);
    `CHK(irq_o, 1'h0)
    attach <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    `CHK(mod_pwr_en_o | mod_io_en_o, 1'h0)
    rd(`AMSE_ADDR_STATUS, 32'h20, 2'h0);
    rd(`AMSE_ADDR_IRQ_STAT, 32'h18, 2'h0);
    done("matching module and removal");
    complete_run();
  end
endmodule // test_adapter_module_status_enable
bind amse_top amse_props #(.EXPECTED_ID(EXPECTED_ID)) u_props (.ref_clk_i, .rst_b_i,
  .mod_present_i, .mod_pwr_good_i, .mod_id_i, .sensor_temp_i, .mod_pwr_en_o, .mod_io_en_o,
  .mod_eeprom_pwr_o, .present_o, .pwr_good_o, .pwr_enabled_o, .io_enabled_o,
  .eeprom_pwr_enabled_o, .expected_id_o, .inserted_id_o, .temp_o);
`default_nettype wire
